// ===== timer2_pkg.sv
package timer2_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Special-function addresses
    localparam logic [7:0] CTRL_ADDR        = 8'hc8;
    localparam logic [7:0] RELOAD_LOW_ADDR  = 8'hca;
    localparam logic [7:0] RELOAD_HIGH_ADDR = 8'hcb;
    localparam logic [7:0] COUNT_LOW_ADDR   = 8'hcc;
    localparam logic [7:0] COUNT_HIGH_ADDR  = 8'hcd;

    ////////////////////////////////////////////////////////////////////////////
    // Control register field positions
    localparam int HIGH_FLAG_BIT   = 7;
    localparam int LOW_FLAG_BIT    = 6;
    localparam int LOW_IRQ_EN_BIT  = 5;
    localparam int CAPTURE_EN_BIT  = 4;
    localparam int SPLIT_BIT       = 3;
    localparam int RUN_BIT         = 2;
    localparam int UNUSED_BIT      = 1;
    localparam int EXT_CLK_SEL_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and divider counts
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] BYTE_RESET   = 8'h00;
    localparam logic [7:0] BYTE_MAX     = 8'hff;
    localparam logic [3:0] SYS_DIV      = 4'hc;
    localparam logic [2:0] EXT_DIV_LAST = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_s;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic       value;
    } bit_req_s;

    typedef struct packed {
        logic high_byte_overflow_flag;
        logic low_byte_overflow_flag;
        logic low_byte_irq_enable;
        logic slow_osc_capture_enable;
        logic split_mode_select;
        logic run_control;
        logic unused;
        logic external_clock_select;
    } timer_two_control_reg_s;

endpackage

// ===== pin_edge_sync.sv
`timescale 1ns/1ps
module pin_edge_sync
    import timer2_pkg::*;
(
    input  wire logic i_clock,
    input  wire logic i_srst,
    input  wire logic i_pin,
    output logic      o_rise,
    output logic      o_fall
);

    logic meta;
    logic stable;
    logic prev;

    // Two flops before anything looks at the pin
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            meta   <= 1'b0;
            stable <= 1'b0;
            prev   <= 1'b0;
        end else begin
            meta   <= i_pin;
            stable <= meta;
            prev   <= stable;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_rise <= 1'b0;
            o_fall <= 1'b0;
        end else begin
            o_rise <= stable & ~prev;
            o_fall <= ~stable & prev;
        end
    end

endmodule

// ===== timer2_control_logic.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] High byte rollover sets high overflow flag
// [RULE2] 16-bit wrap sets high overflow flag
// [RULE3] Enabled high flag raises interrupt request
// [RULE4] Flags cleared only by software writes
// [RULE5] Low byte rollover sets low flag always
// [RULE6] Low flag interrupts when low enable set
// [RULE7] Slow oscillator fall captures count into reload
// [RULE8] Split bit picks 16-bit or two 8-bit
// [RULE9] Run bit counts when one, holds otherwise
// [RULE10] Split mode: run gates only high byte
// [RULE11] Bit 1 reads zero, writes ignored
// [RULE12] External select: system_clock/12 or external/8
// [RULE13] Split: external select applies, byte overrides
// [RULE14] Control at 0xC8, bit-addressable, resets zero
// [RULE15] 16-bit wrap loads reload pair into count
// [RULE16] Capture event also sets high flag
// [RULE17] Byte clock select one picks undivided system_clock
// [RULE18] Hardware set beats same-cycle software clear
module timer2_control_logic
    import timer2_pkg::*;
(
    input  wire logic     i_clock,
    input  wire logic     i_srst,
    input  wire sfr_req_s i_sfr,
    input  wire bit_req_s i_bit,
    input  wire logic     i_timer_irq_enable,
    input  wire logic     i_high_byte_clock_select,
    input  wire logic     i_low_byte_clock_select,
    input  wire logic     i_ext_clock,
    input  wire logic     i_low_frequency_oscillator,
    output logic [7:0]    o_sfr_rdata,
    output logic          o_irq_request
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic sfr_hit(input sfr_req_s r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction

    function automatic logic pick_tick(input logic sys_sel, input logic xclk,
                                       input logic sys12, input logic ext8);
        return sys_sel ? 1'b1 : (xclk ? ext8 : sys12);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    timer_two_control_reg_s ctrl;
    logic [7:0]             count_low;
    logic [7:0]             count_high;
    logic [7:0]             reload_low;
    logic [7:0]             reload_high;
    logic [3:0]             sys_div_count;
    logic [2:0]             ext_div_count;
    logic                   ext_rise;
    logic                   lfo_fall;
    logic [7:0]             next_ctrl;
    logic [15:0]            count_word;
    logic [15:0]            reload_word;

    assign count_word  = {count_high, count_low};
    assign reload_word = {reload_high, reload_low};

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    pin_edge_sync u_ext_sync (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .i_pin   (i_ext_clock),
        .o_rise  (ext_rise),
        .o_fall  ()
    );

    pin_edge_sync u_lfo_sync (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .i_pin   (i_low_frequency_oscillator),
        .o_rise  (),
        .o_fall  (lfo_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock sources

    logic sys_div_tick;
    logic ext_div_tick;
    logic low_tick;
    logic high_tick;

    assign sys_div_tick = (sys_div_count == SYS_DIV - 4'h1);
    assign ext_div_tick = ext_rise && (ext_div_count == EXT_DIV_LAST);

    always_ff @(posedge i_clock) begin
        if (i_srst || sys_div_tick) begin
            sys_div_count <= 4'h0;
        end else begin
            sys_div_count <= sys_div_count + 4'h1;  // [RULE12]
        end
    end

    // External edges only count once synchronised, so the pin rate must
    // stay well under half the system clock
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            ext_div_count <= 3'h0;
        end else if (ext_rise) begin
            ext_div_count <= ext_div_count + 3'h1;  // [RULE12]
        end
    end

    // [RULE13]
    assign low_tick  = pick_tick(i_low_byte_clock_select, ctrl.external_clock_select,
                                 sys_div_tick, ext_div_tick);  // [RULE17]
    assign high_tick = pick_tick(i_high_byte_clock_select, ctrl.external_clock_select,
                                 sys_div_tick, ext_div_tick);  // [RULE17]

    ////////////////////////////////////////////////////////////////////////////
    // Counting

    logic full_tick;
    logic lo_inc;
    logic hi_inc;
    logic low_wrap;
    logic high_wrap;
    logic full_wrap;
    logic capture;
    logic wr_count_low;
    logic wr_count_high;
    logic cnt_sw_wr;

    // In 16-bit mode the low byte clock select drives the whole counter
    assign full_tick = !ctrl.split_mode_select && ctrl.run_control && low_tick;  // [RULE9]
    assign lo_inc    = ctrl.split_mode_select ? low_tick : full_tick;  // [RULE10]
    assign hi_inc    = ctrl.split_mode_select ? (ctrl.run_control && high_tick)
                                              : (full_tick && count_low == BYTE_MAX);  // [RULE8]
    assign low_wrap  = lo_inc && (count_low == BYTE_MAX);
    assign high_wrap = hi_inc && (count_high == BYTE_MAX);  // [RULE1]
    assign full_wrap = !ctrl.split_mode_select && high_wrap;  // [RULE2]
    assign capture   = ctrl.slow_osc_capture_enable && lfo_fall;  // [RULE16]

    assign wr_count_low  = sfr_hit(i_sfr, COUNT_LOW_ADDR);
    assign wr_count_high = sfr_hit(i_sfr, COUNT_HIGH_ADDR);
    assign cnt_sw_wr     = wr_count_low || wr_count_high;

    // Software writes take precedence over a tick in the same cycle
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            count_low <= BYTE_RESET;
        end else if (wr_count_low) begin
            count_low <= i_sfr.wdata;
        end else if (ctrl.split_mode_select ? low_wrap : full_wrap) begin
            count_low <= reload_low;  // [RULE15]
        end else if (lo_inc) begin
            count_low <= count_low + 8'h01;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            count_high <= BYTE_RESET;
        end else if (wr_count_high) begin
            count_high <= i_sfr.wdata;
        end else if (high_wrap) begin
            count_high <= reload_high;  // [RULE15]
        end else if (hi_inc) begin
            count_high <= count_high + 8'h01;
        end
    end

    // A capture beats a software write so no measurement is dropped
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            reload_low  <= BYTE_RESET;
            reload_high <= BYTE_RESET;
        end else if (capture) begin
            reload_low  <= count_low;  // [RULE7]
            reload_high <= count_high;
        end else begin
            if (sfr_hit(i_sfr, RELOAD_LOW_ADDR)) begin
                reload_low <= i_sfr.wdata;
            end
            if (sfr_hit(i_sfr, RELOAD_HIGH_ADDR)) begin
                reload_high <= i_sfr.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register

    logic ctrl_sw_wr;
    logic bit_hit;

    assign bit_hit    = i_bit.wr && (i_bit.addr[7:3] == CTRL_ADDR[7:3]);
    assign ctrl_sw_wr = sfr_hit(i_sfr, CTRL_ADDR) || bit_hit;

    always_comb begin
        next_ctrl = ctrl;
        if (sfr_hit(i_sfr, CTRL_ADDR)) begin
            next_ctrl = i_sfr.wdata;
        end else if (bit_hit) begin
            next_ctrl[i_bit.addr[2:0]] = i_bit.value;  // [RULE14]
        end
        next_ctrl[UNUSED_BIT] = 1'b0;  // [RULE11]
        // OR-ing after the write lets a hardware set win over a clear
        next_ctrl[HIGH_FLAG_BIT] = next_ctrl[HIGH_FLAG_BIT] | high_wrap | capture;  // [RULE18]
        next_ctrl[LOW_FLAG_BIT]  = next_ctrl[LOW_FLAG_BIT] | low_wrap;  // [RULE5]
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            ctrl <= timer_two_control_reg_s'(CTRL_RESET);  // [RULE14]
        end else begin
            ctrl <= timer_two_control_reg_s'(next_ctrl);  // [RULE4]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port and interrupt

    always_ff @(posedge i_clock) begin
        if (i_srst || !i_sfr.rd) begin
            o_sfr_rdata <= 8'h00;
        end else if (i_sfr.addr == CTRL_ADDR) begin
            o_sfr_rdata <= ctrl;
        end else if (i_sfr.addr == RELOAD_LOW_ADDR) begin
            o_sfr_rdata <= reload_low;
        end else if (i_sfr.addr == RELOAD_HIGH_ADDR) begin
            o_sfr_rdata <= reload_high;
        end else if (i_sfr.addr == COUNT_LOW_ADDR) begin
            o_sfr_rdata <= count_low;
        end else if (i_sfr.addr == COUNT_HIGH_ADDR) begin
            o_sfr_rdata <= count_high;
        end else begin
            o_sfr_rdata <= 8'h00;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_irq_request <= 1'b0;
        end else begin
            o_irq_request <= i_timer_irq_enable &&  // [RULE3]
                (ctrl.high_byte_overflow_flag ||
                 (ctrl.low_byte_irq_enable && ctrl.low_byte_overflow_flag));  // [RULE6]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    sequence s_full_wrap;
        !ctrl.split_mode_select && ctrl.run_control && low_tick &&
        count_word == 16'hffff;
    endsequence

    sequence s_sys_period;
        sys_div_tick ##1 (!sys_div_tick) [*8] ##1 !sys_div_tick ##1 !sys_div_tick
        ##1 !sys_div_tick;
    endsequence

    chk_high_byte_wrap: assert property ( // [RULE1]
        ctrl.split_mode_select && high_wrap |=> ctrl.high_byte_overflow_flag)
        else $error("high byte rollover did not set its flag");

    chk_full_wrap_flag: assert property ( // [RULE2]
        s_full_wrap |=> ctrl.high_byte_overflow_flag)
        else $error("16-bit wrap did not set high flag");

    chk_full_reload: assert property ( // [RULE15]
        s_full_wrap ##0 !cnt_sw_wr |=> count_word == $past(reload_word))
        else $error("16-bit wrap did not load reload pair");

    chk_irq_high: assert property ( // [RULE3]
        i_timer_irq_enable && ctrl.high_byte_overflow_flag |=> o_irq_request)
        else $error("high flag did not raise interrupt");

    chk_flag_sticky: assert property ( // [RULE4]
        ctrl.high_byte_overflow_flag && !ctrl_sw_wr |=> ctrl.high_byte_overflow_flag)
        else $error("high flag cleared without software");

    chk_low_wrap: assert property ( // [RULE5]
        low_wrap |=> ctrl.low_byte_overflow_flag)
        else $error("low rollover did not set low flag");

    chk_irq_low: assert property ( // [RULE6]
        i_timer_irq_enable && ctrl.low_byte_irq_enable && ctrl.low_byte_overflow_flag
        && !ctrl.high_byte_overflow_flag |=> o_irq_request)
        else $error("low flag did not raise interrupt");

    chk_capture_copy: assert property ( // [RULE7]
        capture |=> reload_word == $past(count_word) && ctrl.high_byte_overflow_flag)
        else $error("capture did not copy count or set flag");

    chk_run_hold: assert property ( // [RULE9]
        !ctrl.run_control && !ctrl.split_mode_select && !cnt_sw_wr |=> $stable(count_word))
        else $error("count moved while stopped");

    chk_split_low_free: assert property ( // [RULE10]
        ctrl.split_mode_select && !ctrl.run_control && low_tick && !wr_count_low
        && count_low != BYTE_MAX |=> count_low == $past(count_low) + 8'h01)
        else $error("split low byte did not run free");

    chk_bit1_zero: assert property ( // [RULE11]
        i_sfr.rd && i_sfr.addr == CTRL_ADDR |=> o_sfr_rdata[UNUSED_BIT] == 1'b0)
        else $error("unused control bit read as one");

    chk_sys_period: assert property ( // [RULE12]
        sys_div_tick |-> s_sys_period ##1 sys_div_tick)
        else $error("system divider not twelve cycles");

    chk_set_wins: assert property ( // [RULE18]
        low_wrap && ctrl_sw_wr |=> ctrl.low_byte_overflow_flag)
        else $error("software clear beat hardware set");

endmodule

// ===== timer2_control_logic_test.sv
`timescale 1ns/1ps
module timer2_control_logic_test;
    import timer2_pkg::*;

    logic       i_clock            = 1'b0;
    logic       i_srst             = 1'b1;
    sfr_req_s   i_sfr              = '0;
    bit_req_s   i_bit              = '0;
    logic       i_timer_irq_enable = 1'b0;
    logic       hi_sel             = 1'b0;
    logic       lo_sel             = 1'b0;
    logic       ext_clk            = 1'b0;
    logic       low_frequency_oscillator                = 1'b1;
    logic [7:0] o_sfr_rdata;
    logic       o_irq_request;
    logic [7:0] rd_a;
    logic [7:0] rd_b;
    int         failures           = 0;
    int         tests_run          = 0;

    always #2 i_clock = ~i_clock;

    timer2_control_logic dut_u (
        .i_clock                    (i_clock),
        .i_srst                     (i_srst),
        .i_sfr                      (i_sfr),
        .i_bit                      (i_bit),
        .i_timer_irq_enable         (i_timer_irq_enable),
        .i_high_byte_clock_select   (hi_sel),
        .i_low_byte_clock_select    (lo_sel),
        .i_ext_clock                (ext_clk),
        .i_low_frequency_oscillator (low_frequency_oscillator),
        .o_sfr_rdata                (o_sfr_rdata),
        .o_irq_request              (o_irq_request)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Every task starts and ends just after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_range(input logic [7:0] got, input logic [7:0] lo,
                               input logic [7:0] hi, input string what);
        tests_run++;
        if (!(got >= lo && got <= hi) || $isunknown(got)) begin
            failures++;
            $display("wrong value at %0t: %s got %h outside %h..%h", $time, what, got, lo, hi);
        end
    endtask

    // Request is held across the taking edge, then a quiet cycle keeps strobes apart
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        i_sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        step(1);
        i_sfr = '0;
        step(1);
    endtask

    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        i_sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        step(1);
        d = o_sfr_rdata;
        i_sfr = '0;
        step(1);
    endtask

    task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        sfr_read(a, d);
        check8(d, exp, $sformatf("read of %h", a));
    endtask

    task automatic bit_write(input logic [2:0] idx, input logic v);
        i_bit = '{wr: 1'b1, addr: {CTRL_ADDR[7:3], idx}, value: v};
        step(1);
        i_bit = '0;
        step(1);
    endtask

    // Bounded wait for the interrupt line; running out ends the run
    task automatic expect_irq(input logic v);
        int n;
        n = 0;
        while (o_irq_request !== v && n < 8) begin
            step(1);
            n++;
        end
        tests_run++;
        if (o_irq_request !== v) begin
            failures++;
            $display("wrong value at %0t: interrupt line not %b", $time, v);
            report_and_stop();
        end
    endtask

    task automatic set_count(input logic [7:0] hi, input logic [7:0] lo);
        sfr_write(COUNT_HIGH_ADDR, hi);
        sfr_write(COUNT_LOW_ADDR, lo);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        step(8);
        i_srst = 1'b0;
        step(3);

        read_check(CTRL_ADDR, CTRL_RESET);
        read_check(8'hc9, 8'h00);
        expect_irq(1'b0);
        sfr_write(CTRL_ADDR, 8'h02);
        read_check(CTRL_ADDR, 8'h00);
        bit_write(3'h1, 1'b1);
        read_check(CTRL_ADDR, 8'h00);
        bit_write(3'h3, 1'b1);
        bit_write(3'h0, 1'b1);
        read_check(CTRL_ADDR, 8'h09);
        sfr_write(CTRL_ADDR, 8'h00);
        $display("test register access done");

        // 16-bit wrap from fffd with the undivided clock
        lo_sel = 1'b1;
        sfr_write(RELOAD_LOW_ADDR, 8'h34);
        sfr_write(RELOAD_HIGH_ADDR, 8'h12);
        set_count(8'hff, 8'hfd);
        sfr_write(CTRL_ADDR, 8'h04);
        step(20);
        bit_write(3'h2, 1'b0);
        read_check(CTRL_ADDR, 8'hc0);
        read_check(COUNT_HIGH_ADDR, 8'h12);
        read_check(RELOAD_HIGH_ADDR, 8'h12);
        sfr_read(COUNT_LOW_ADDR, rd_a);
        step(10);
        sfr_read(COUNT_LOW_ADDR, rd_b);
        check8(rd_b, rd_a, "held count");
        step(30);
        read_check(CTRL_ADDR, 8'hc0);
        $display("test sixteen bit wrap done");

        i_timer_irq_enable = 1'b1;
        expect_irq(1'b1);
        bit_write(3'h7, 1'b0);
        read_check(CTRL_ADDR, 8'h40);
        expect_irq(1'b0);
        bit_write(3'h5, 1'b1);
        expect_irq(1'b1);
        sfr_write(CTRL_ADDR, 8'h00);
        expect_irq(1'b0);
        $display("test interrupt done");

        // Split mode with run off: only the low byte moves
        hi_sel = 1'b1;
        sfr_write(RELOAD_LOW_ADDR, 8'hf0);
        set_count(8'h55, 8'hf0);
        sfr_write(CTRL_ADDR, 8'h08);
        step(40);
        read_check(CTRL_ADDR, 8'h48);
        read_check(COUNT_HIGH_ADDR, 8'h55);
        sfr_read(COUNT_LOW_ADDR, rd_a);
        check_range(rd_a, 8'hf0, 8'hff, "split low byte");
        sfr_write(RELOAD_HIGH_ADDR, 8'h80);
        sfr_write(COUNT_HIGH_ADDR, 8'hfe);
        bit_write(3'h2, 1'b1);
        step(10);
        bit_write(3'h2, 1'b0);
        read_check(CTRL_ADDR, 8'hc8);
        sfr_read(COUNT_HIGH_ADDR, rd_a);
        check_range(rd_a, 8'h80, 8'h8f, "split high byte");
        sfr_write(CTRL_ADDR, 8'h00);
        // Clear of the low flag lands on the very cycle of a wrap
        sfr_write(RELOAD_LOW_ADDR, 8'h00);
        set_count(8'h00, 8'hfe);
        sfr_write(CTRL_ADDR, 8'h08);
        bit_write(3'h6, 1'b0);
        read_check(CTRL_ADDR, 8'h48);
        sfr_write(CTRL_ADDR, 8'h00);
        $display("test split mode done");

        // Divided sources: a system_clock/12 run gives about ten ticks here
        lo_sel = 1'b0;
        hi_sel = 1'b0;
        set_count(8'h00, 8'h00);
        bit_write(3'h2, 1'b1);
        step(120);
        bit_write(3'h2, 1'b0);
        sfr_read(COUNT_LOW_ADDR, rd_a);
        check_range(rd_a, 8'h09, 8'h0b, "system_clock over twelve");
        set_count(8'h00, 8'h00);
        sfr_write(CTRL_ADDR, 8'h05);
        repeat (64) begin
            ext_clk = 1'b1;
            step(2);
            ext_clk = 1'b0;
            step(2);
        end
        bit_write(3'h2, 1'b0);
        sfr_read(COUNT_LOW_ADDR, rd_a);
        check_range(rd_a, 8'h07, 8'h08, "external over eight");
        sfr_write(CTRL_ADDR, 8'h00);
        // Split with external select and no pin edges: only the override moves
        hi_sel = 1'b1;
        set_count(8'h00, 8'h10);
        sfr_write(CTRL_ADDR, 8'h0d);
        step(10);
        bit_write(3'h2, 1'b0);
        read_check(COUNT_LOW_ADDR, 8'h10);
        sfr_read(COUNT_HIGH_ADDR, rd_a);
        check_range(rd_a, 8'h0a, 8'h10, "high byte override");
        sfr_write(CTRL_ADDR, 8'h00);
        hi_sel = 1'b0;
        $display("test clock select done");

        // Capture on the slow oscillator falling edge
        lo_sel = 1'b1;
        set_count(8'h00, 8'h00);
        sfr_write(RELOAD_LOW_ADDR, 8'h00);
        sfr_write(RELOAD_HIGH_ADDR, 8'h00);
        sfr_write(CTRL_ADDR, 8'h14);
        step(20);
        low_frequency_oscillator = 1'b0;
        step(10);
        read_check(CTRL_ADDR, 8'h94);
        expect_irq(1'b1);
        bit_write(3'h2, 1'b0);
        read_check(RELOAD_HIGH_ADDR, 8'h00);
        sfr_read(RELOAD_LOW_ADDR, rd_a);
        check_range(rd_a, 8'h0f, 8'h28, "captured count");
        low_frequency_oscillator = 1'b1;
        sfr_write(CTRL_ADDR, 8'h00);
        expect_irq(1'b0);
        $display("test capture done");

        report_and_stop();
    end
endmodule
